/* File: include/pwa_defs.svh */
// Constants of the page walk agent: opcodes, entry bits, link layouts.
// Included by the package and by every design file; definitions only.
`ifndef PWA_DEFS_SVH
`define PWA_DEFS_SVH
`define PWA_OP_HI     4'hc
`define PWA_P_BIT     0
`define PWA_W_BIT     1
`define PWA_U_BIT     2
`define PWA_A_BIT     5
`define PWA_D_BIT     6
`define PWA_LAST_LVL  2'h3
`define PWA_BEAT_LAST 2'h3
`define PWA_REQ_W     50
`define PWA_RSP_W     48
`define PWA_RQ_BW     13
`define PWA_RS_BW     12
`define PWA_RQ_OP     0
`define PWA_RQ_ID     3:0
`define PWA_RQ_SL     1
`define PWA_RQ_CL     3:2
`define PWA_RQ_VA     39:4
`define PWA_RQ_RW     40
`define PWA_RQ_TAG    48:41
`define PWA_RQ_FLT    49
`define PWA_RSP_PAGE  2'h0
`define PWA_RSP_INV_S 2'h2
`define PWA_RSP_INV_E 2'h3
`define PWA_FLT_NONE  2'h0
`define PWA_FLT_NP    2'h1
`define PWA_FLT_PRIV  2'h2
`define PWA_FLT_WR    2'h3
`define PWA_MT_UC     3'h0
`define PWA_MT_WC     3'h1
`define PWA_MT_WT     3'h4
`define PWA_TLB_N     8
`define PWA_ASID_W    20
`define PWA_NCL       8
`endif

/* File: include/pwa_pkg.sv */
// Types shared by the page walk agent files.
// Needs pwa_defs.svh on the include path.
`include "pwa_defs.svh"
package pwa_pkg;
    typedef enum logic [2:0] {
        PWA_IDLE, PWA_LOOK, PWA_WREQ, PWA_WAIT,
        PWA_RESP, PWA_INV_S, PWA_INV_ACK, PWA_INV_E
    } pwa_state_t;
    typedef logic [`PWA_REQ_W-1:0] pwa_req_t;
    typedef logic [`PWA_RSP_W-1:0] pwa_rsp_t;
endpackage

/* File: rtl/pwa_req_deser.sv */
// Request link receiver: four beats in, one request into a 2-deep queue.
// Assumes the sender keeps beat_valid high for the four beats of a request.
`timescale 1ns/10ps
`include "pwa_defs.svh"
module pwa_req_deser
    import pwa_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  beat_valid,
    input  wire logic [`PWA_RQ_BW-1:0] beat_data,
    input  wire logic                  pop,
    output logic                       head_valid,
    output pwa_req_t                   head
);
    logic [1:0]  bcnt_r;
    logic [38:0] acc_r;
    pwa_req_t    q_r [2];
    logic        wp_r;
    logic        rp_r;
    logic [1:0]  n_r;
    wire  [51:0] whole = {beat_data, acc_r};
    wire         push  = beat_valid & (bcnt_r == `PWA_BEAT_LAST);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bcnt_r <= 2'h0;
            acc_r  <= 39'h0;
        end else begin
            bcnt_r <= beat_valid ? bcnt_r + 2'h1 : 2'h0;
            acc_r  <= {beat_data, acc_r[38:13]};
        end
    end

    // The queue never overflows while the sender spends only its two credits.
    always_ff @(posedge mclk) begin
        if (push)
            q_r[wp_r] <= whole[`PWA_REQ_W-1:0];
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            n_r  <= 2'h0;
        end else begin
            wp_r <= wp_r ^ push;
            rp_r <= rp_r ^ pop;
            n_r  <= n_r + {1'b0, push} - {1'b0, pop};
        end
    end

    assign head_valid = (n_r != 2'h0);
    assign head       = q_r[rp_r];

    a_queue_room: assert property (@(posedge mclk) disable iff (!rst_n)
        push |-> (n_r < 2'h2) || pop) else $error("request queue overrun");
    a_four_beats: assert property (@(posedge mclk) disable iff (!rst_n)
        push |-> $past(beat_valid) && $past(beat_valid, 2) && $past(beat_valid, 3))
        else $error("request taken with fewer than four beats");
endmodule // pwa_req_deser

/* File: rtl/pwa_walker.sv */
// Page walk agent: main TLB, walks with A/D atomics, cluster walk port.
// Assumes the ring interface runs the atomic ALU and returns the new entry.
`timescale 1ns/10ps
// Behaviour
// - Set accessed bit on every used entry.
// - Writes set dirty bit in final entry.
// - Never clear accessed or dirty bits.
// - Accessed at all levels, dirty final only.
// - Commit only after atomic flag update returns.
// - Opcode 1100, write/ext/wp/intermediate bits.
// - Ring ALU sets 5, 6, 10; returns entry.
// - Control bit: ignore cacheability or detect non-WB.
// - Non-WB update under detection: catastrophic error.
// - Victims chosen least recently allocated.
// - Context reload invalidates the TLB.
// - Page response kills matching faulted entries.
// - Wait answer only after ring drained.
// - Cache faulted entries only for faultable requests.
// - Look up TLB, walk on miss, respond.
// - Two credits, two-deep queue per port.
// - Arbitrate slice requests toward the walker.
// - One request per four clocks, serialized.
// - Broadcast at most one response per four clocks.
// - Response opcodes: page, reserved, start, end.
// - Page response fields and widths as defined.
// - Fault codes: none, absent, privilege, write.
// - Invalidate: drop requests, await acks, send end.
`include "pwa_defs.svh"
module pwa_walker
    import pwa_pkg::*;
(
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire logic                   rq0_bv,
    input  wire logic [`PWA_RQ_BW-1:0]  rq0_bd,
    input  wire logic                   rq1_bv,
    input  wire logic [`PWA_RQ_BW-1:0]  rq1_bd,
    output logic                        rsp_bv,
    output logic [`PWA_RS_BW-1:0]       rsp_bd,
    output logic                        ring_req_valid,
    output logic [7:0]                  ring_req_op,
    output logic [38:0]                 ring_req_addr,
    input  wire logic                   ring_req_ready,
    input  wire logic                   ring_rsp_valid,
    input  wire logic [63:0]            ring_rsp_data,
    input  wire logic [2:0]             ring_rsp_mtype,
    input  wire logic                   ring_interface_drained,
    input  wire logic [26:0]            pt_root,
    input  wire logic [`PWA_ASID_W-1:0] ctx_asid,
    input  wire logic                   user_ctx,
    input  wire logic                   ext_access_en,
    input  wire logic                   wp_en,
    input  wire logic                   nonwb_ignore,
    input  wire logic                   ctx_reload,
    input  wire logic                   inv_start,
    input  wire logic                   inv_wait_req,
    output logic                        inv_wait_done,
    input  wire logic                   pg_resp_valid,
    input  wire logic [35:0]            pg_resp_va,
    input  wire logic [`PWA_ASID_W-1:0] pg_resp_asid,
    input  wire logic [`PWA_NCL-1:0]    cluster_present,
    output logic                        cat_error
);
    localparam int N = `PWA_TLB_N;

    // ----------------------------------------------------------------
    // Slice ports and arbitration
    // ----------------------------------------------------------------
    pwa_state_t st_r;
    pwa_req_t   h0, h1, cur_r;
    logic       hv0, hv1;
    logic       rr_r;
    logic       inv_pend_r;
    logic       pop0, pop1;

    pwa_req_deser u_dq0 (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .beat_valid (rq0_bv),
        .beat_data  (rq0_bd),
        .pop        (pop0),
        .head_valid (hv0),
        .head       (h0)
    );
    pwa_req_deser u_dq1 (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .beat_valid (rq1_bv),
        .beat_data  (rq1_bd),
        .pop        (pop1),
        .head_valid (hv1),
        .head       (h1)
    );

    wire      pick1 = hv1 & (!hv0 | rr_r);
    pwa_req_t head;
    assign    head  = pick1 ? h1 : h0;
    wire      take  = (st_r == PWA_IDLE) & !inv_pend_r & (hv0 | hv1);
    wire      drain = (st_r == PWA_INV_ACK);
    // Queued requests are dropped while clusters are being invalidated.
    assign    pop0  = drain ? hv0 : take & !pick1;
    assign    pop1  = drain ? hv1 : take & pick1;

    wire        cur_wr  = cur_r[`PWA_RQ_RW];
    wire [35:0] cur_va  = cur_r[`PWA_RQ_VA];
    wire        cur_flt = cur_r[`PWA_RQ_FLT];

    // ----------------------------------------------------------------
    // Main TLB
    // ----------------------------------------------------------------
    logic [N-1:0]            tv_r;
    logic                    tf_r  [N];
    logic                    td_r  [N];
    logic                    tw_r  [N];
    logic                    trw_r [N];
    logic [35:0]             tva_r [N];
    logic [`PWA_ASID_W-1:0]  tas_r [N];
    logic [26:0]             tpa_r [N];
    logic [2:0]              tmt_r [N];
    logic [1:0]              tfc_r [N];
    logic [2:0]              aptr_r;
    wire  [N-1:0]            tag_m, hit_v, pr_m;

    for (genvar g = 0; g < N; g++) begin : g_match
        assign tag_m[g] = tv_r[g] & (tva_r[g] == cur_va) & (tas_r[g] == ctx_asid);
        // A write on an unfaulted entry without dirty or write right misses and rewalks.
        assign hit_v[g] = tag_m[g] & (tf_r[g] ? (trw_r[g] == cur_wr)
                                               : (!cur_wr | (td_r[g] & tw_r[g])));
        assign pr_m[g]  = tv_r[g] & tf_r[g] & pg_resp_valid
                        & (tva_r[g] == pg_resp_va) & (tas_r[g] == pg_resp_asid);
    end

    logic [2:0] hidx;
    always_comb begin
        hidx = 3'h0;
        for (int i = 0; i < N; i++)
            if (hit_v[i])
                hidx = 3'(i);
    end
    wire hit = |hit_v;

    // ----------------------------------------------------------------
    // Walk datapath
    // ----------------------------------------------------------------
    logic [1:0]  lvl_r;
    logic [26:0] base_r;
    logic        wacc_r, uacc_r;
    logic        rv_r;
    logic [7:0]  rop_r;
    logic [38:0] radd_r;
    pwa_rsp_t    pk_r;

    wire        last = (lvl_r == `PWA_LAST_LVL);
    wire [8:0]  idx  = (lvl_r == 2'h0) ? cur_va[35:27] :
                       (lvl_r == 2'h1) ? cur_va[26:18] :
                       (lvl_r == 2'h2) ? cur_va[17:9] : cur_va[8:0];
    // Write intent only at the final level keeps dirty off intermediate entries.
    wire [7:0]  op_nxt = {`PWA_OP_HI, !last, wp_en, ext_access_en, cur_wr & last};
    wire [63:0] ent   = ring_rsp_data;
    wire        got   = (st_r == PWA_WAIT) & ring_rsp_valid;
    wire        w_now = wacc_r & ent[`PWA_W_BIT];
    wire        u_now = uacc_r & ent[`PWA_U_BIT];
    wire [1:0]  fc    = !ent[`PWA_P_BIT]      ? `PWA_FLT_NP :
                        (user_ctx & !u_now)   ? `PWA_FLT_PRIV :
                        (cur_wr & !w_now)     ? `PWA_FLT_WR : `PWA_FLT_NONE;
    wire        mt_bad = (ring_rsp_mtype == `PWA_MT_UC) | (ring_rsp_mtype == `PWA_MT_WC)
                       | (ring_rsp_mtype == `PWA_MT_WT);
    wire        nonwb_err = got & mt_bad & !nonwb_ignore;
    wire        done  = got & (last | (fc != `PWA_FLT_NONE) | nonwb_err);
    wire        alloc = done & !nonwb_err & ((fc == `PWA_FLT_NONE) | cur_flt);
    wire [1:0]  wfc   = nonwb_err ? `PWA_FLT_NP : fc;

    function automatic pwa_rsp_t mk_pkt(input logic [26:0] pa, input logic d,
                                        input logic [1:0] f, input logic [2:0] mt);
        mk_pkt = {cur_r[`PWA_RQ_TAG], mt, f, d, cur_r[`PWA_RQ_CL],
                  1'b0, cur_r[`PWA_RQ_SL], cur_wr, pa, `PWA_RSP_PAGE};
    endfunction

    pwa_rsp_t pk_hit, pk_walk;
    assign pk_hit  = mk_pkt(tpa_r[hidx], td_r[hidx],
                            tf_r[hidx] ? tfc_r[hidx] : `PWA_FLT_NONE, tmt_r[hidx]);
    assign pk_walk = mk_pkt(ent[38:12], ent[`PWA_D_BIT], wfc, ring_rsp_mtype);

    // ----------------------------------------------------------------
    // Response serializer
    // ----------------------------------------------------------------
    logic [`PWA_RSP_W-1:0] sh_r;
    logic [1:0]            cnt_r;
    logic                  bv_r;
    logic [`PWA_RS_BW-1:0] bd_r;
    logic [`PWA_NCL-1:0]   ack_r;

    wire ser_free = (cnt_r == 2'h0);
    wire ld = ser_free & ((st_r == PWA_RESP) | (st_r == PWA_INV_S) | (st_r == PWA_INV_E));
    pwa_rsp_t ld_pk;
    assign ld_pk = (st_r == PWA_RESP) ? pk_r :
                   {46'h0, (st_r == PWA_INV_S) ? `PWA_RSP_INV_S : `PWA_RSP_INV_E};

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bv_r  <= 1'b0;
            bd_r  <= 12'h0;
            sh_r  <= 48'h0;
            cnt_r <= 2'h0;
        end else if (ld) begin
            bv_r  <= 1'b1;
            bd_r  <= ld_pk[11:0];
            sh_r  <= {12'h0, ld_pk[47:12]};
            cnt_r <= `PWA_BEAT_LAST;
        end else if (!ser_free) begin
            bd_r  <= sh_r[11:0];
            sh_r  <= {12'h0, sh_r[47:12]};
            cnt_r <= cnt_r - 2'h1;
        end else begin
            bv_r  <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Invalidation bookkeeping
    // ----------------------------------------------------------------
    // The acknowledge bit index is {slice, cluster}, the same order as cluster_present.
    wire [`PWA_NCL-1:0] ack0 = (pop0 & h0[`PWA_RQ_OP]) ? 8'h1 << {h0[`PWA_RQ_SL], h0[`PWA_RQ_CL]} : 8'h0;
    wire [`PWA_NCL-1:0] ack1 = (pop1 & h1[`PWA_RQ_OP]) ? 8'h1 << {h1[`PWA_RQ_SL], h1[`PWA_RQ_CL]} : 8'h0;
    wire all_ack = ((ack_r & cluster_present) == cluster_present);
    logic inv_wait_req_pend;
    // A second flush at the start broadcast catches walks finished meanwhile.
    wire flush = ctx_reload | inv_start | ((st_r == PWA_INV_S) & ld);
    wire wdone = inv_wait_req_pend & ring_interface_drained
               & (st_r != PWA_WREQ) & (st_r != PWA_WAIT);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            inv_pend_r        <= 1'b0;
            inv_wait_req_pend <= 1'b0;
            ack_r             <= 8'h0;
        end else begin
            inv_pend_r        <= ctx_reload | inv_start | (inv_pend_r & (st_r != PWA_IDLE));
            inv_wait_req_pend <= inv_wait_req | (inv_wait_req_pend & !wdone);
            ack_r             <= ((st_r == PWA_INV_S) & ld) ? 8'h0 : (ack_r | ack0 | ack1);
        end
    end

    // ----------------------------------------------------------------
    // TLB update
    // ----------------------------------------------------------------
    wire [N-1:0] kill = pr_m | (((st_r == PWA_LOOK) & !hit) ? tag_m : 8'h0);
    wire [N-1:0] aset = alloc ? (8'h1 << aptr_r) : 8'h0;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tv_r   <= 8'h0;
            aptr_r <= 3'h0;
        end else begin
            tv_r   <= flush ? 8'h0 : ((tv_r & ~kill) | aset);
            aptr_r <= aptr_r + {2'h0, alloc};
        end
    end

    always_ff @(posedge mclk) begin
        if (alloc) begin
            tva_r[aptr_r] <= cur_va;
            tas_r[aptr_r] <= ctx_asid;
            tpa_r[aptr_r] <= ent[38:12];
            tmt_r[aptr_r] <= ring_rsp_mtype;
            td_r[aptr_r]  <= ent[`PWA_D_BIT];
            tw_r[aptr_r]  <= w_now;
            tf_r[aptr_r]  <= (fc != `PWA_FLT_NONE);
            tfc_r[aptr_r] <= fc;
            trw_r[aptr_r] <= cur_wr;
        end
    end

    // ----------------------------------------------------------------
    // Control sequence
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r   <= PWA_IDLE;
            cur_r  <= 50'h0;
            pk_r   <= 48'h0;
            rr_r   <= 1'b0;
            lvl_r  <= 2'h0;
            base_r <= 27'h0;
            wacc_r <= 1'b1;
            uacc_r <= 1'b1;
            rv_r   <= 1'b0;
            rop_r  <= 8'h0;
            radd_r <= 39'h0;
        end else begin
            case (st_r)
                PWA_IDLE: begin
                    if (inv_pend_r) begin
                        st_r <= PWA_INV_S;
                    end else if (take) begin
                        rr_r <= !pick1;
                        if (!head[`PWA_RQ_OP]) begin
                            cur_r <= head;
                            st_r  <= PWA_LOOK;
                        end
                    end
                end
                PWA_LOOK: begin
                    if (hit) begin
                        pk_r <= pk_hit;
                        st_r <= PWA_RESP;
                    end else begin
                        lvl_r  <= 2'h0;
                        base_r <= pt_root;
                        wacc_r <= 1'b1;
                        uacc_r <= 1'b1;
                        st_r   <= PWA_WREQ;
                    end
                end
                PWA_WREQ: begin
                    if (!rv_r) begin
                        rv_r   <= 1'b1;
                        rop_r  <= op_nxt;
                        radd_r <= {base_r, idx, 3'h0};
                    end else if (ring_req_ready) begin
                        rv_r <= 1'b0;
                        st_r <= PWA_WAIT;
                    end
                end
                PWA_WAIT: begin
                    if (done) begin
                        pk_r <= pk_walk;
                        st_r <= PWA_RESP;
                    end else if (got) begin
                        lvl_r  <= lvl_r + 2'h1;
                        base_r <= ent[38:12];
                        wacc_r <= w_now;
                        uacc_r <= u_now;
                        st_r   <= PWA_WREQ;
                    end
                end
                PWA_RESP:    if (ser_free) st_r <= PWA_IDLE;
                PWA_INV_S:   if (ser_free) st_r <= PWA_INV_ACK;
                PWA_INV_ACK: if (all_ack) st_r <= PWA_INV_E;
                PWA_INV_E:   if (ser_free) st_r <= PWA_IDLE;
                default:     st_r <= PWA_IDLE;
            endcase
        end
    end

    logic cat_r, wd_r;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cat_r <= 1'b0;
            wd_r  <= 1'b0;
        end else begin
            cat_r <= nonwb_err;
            wd_r  <= wdone;
        end
    end

    assign rsp_bv         = bv_r;
    assign rsp_bd         = bd_r;
    assign ring_req_valid = rv_r;
    assign ring_req_op    = rop_r;
    assign ring_req_addr  = radd_r;
    assign cat_error      = cat_r;
    assign inv_wait_done  = wd_r;

    a_op_nibble: assert property (@(posedge mclk) disable iff (!rst_n)
        rv_r |-> rop_r[7:4] == `PWA_OP_HI) else $error("walk atomic opcode prefix wrong");
    a_dirty_final: assert property (@(posedge mclk) disable iff (!rst_n)
        rv_r && rop_r[3] |-> !rop_r[0]) else $error("dirty requested on intermediate entry");
    a_write_final: assert property (@(posedge mclk) disable iff (!rst_n)
        rv_r && (lvl_r == `PWA_LAST_LVL) |-> rop_r[0] == cur_wr) else $error("final write opcode wrong");
    a_req_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        rv_r && !ring_req_ready |=> rv_r && $stable(radd_r) && $stable(rop_r))
        else $error("ring request dropped before taken");
    a_resp_beats: assert property (@(posedge mclk) disable iff (!rst_n)
        ld |=> bv_r [*4]) else $error("response not four beats long");
    a_cat_error: assert property (@(posedge mclk) disable iff (!rst_n)
        got && mt_bad && !nonwb_ignore |=> cat_r && (st_r == PWA_RESP) && (pk_r[36:35] != `PWA_FLT_NONE))
        else $error("non-WB update not flagged");
    a_wait_fence: assert property (@(posedge mclk) disable iff (!rst_n)
        wd_r |-> $past(ring_interface_drained)) else $error("wait answered before drain");
    a_ctx_flush: assert property (@(posedge mclk) disable iff (!rst_n)
        ctx_reload |=> tv_r == 8'h0) else $error("context reload left TLB entries");
    a_inv_end: assert property (@(posedge mclk) disable iff (!rst_n)
        ld && (st_r == PWA_INV_E) |-> (ack_r & cluster_present) == cluster_present)
        else $error("invalidation end before all acks");
    a_tag_echo: assert property (@(posedge mclk) disable iff (!rst_n)
        ld && (st_r == PWA_RESP) |-> ld_pk[47:40] == cur_r[`PWA_RQ_TAG] && ld_pk[33:32] == cur_r[`PWA_RQ_CL])
        else $error("tracking number not echoed");
endmodule // pwa_walker

/* File: testbench/pwa_ring_model.sv */
// Ring interface model: runs the page-walk atomic ALU on a synthetic table.
// Each entry points at the next table, base plus one; ready and latency vary.
// Memory type 5 clears the user bit, so that a user context takes a privilege fault.
`timescale 1ns/10ps
module pwa_ring_model (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        req_valid,
    input  wire logic [7:0]  req_op,
    input  wire logic [38:0] req_addr,
    input  wire logic [2:0]  mtype,
    input  wire logic        slow,
    output logic             req_ready,
    output logic             rsp_valid,
    output logic [63:0]      rsp_data,
    output logic [2:0]       rsp_mtype,
    output logic             drained
);
    logic        busy_r;
    logic [3:0]  wait_r;
    logic [63:0] ent_r;
    assign drained = !busy_r && !req_valid;
    // Data toggles outside a result so that a stale read cannot pass.
    always @(posedge mclk) begin
        rsp_valid <= 1'b0;
        rsp_data  <= ~rsp_data;
        if (!rst_n) begin
            req_ready <= 1'b0;
            busy_r    <= 1'b0;
            rsp_data  <= 64'h0;
        end else if (busy_r) begin
            wait_r <= wait_r - 4'h1;
            if (wait_r == 4'h0) begin
                busy_r    <= 1'b0;
                rsp_valid <= 1'b1;
                rsp_data  <= ent_r;
            end
        end else if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            busy_r    <= 1'b1;
            wait_r    <= slow ? 4'hf : 4'($urandom_range(3));
            ent_r     <= {25'h0, req_addr[38:12] + 27'h1, 12'h023 | {9'h0, mtype != 3'h5, 2'h0}}
                       | {53'h0, req_op[1], 3'h0, req_op[0], 6'h0};
            rsp_mtype <= mtype;
        end else begin
            req_ready <= 1'($urandom);
        end
    end
endmodule // pwa_ring_model

/* File: testbench/pwa_walker_tb_top.sv */
// Testbench of the walker: clusters on both slice ports, ring model behind.
// Expected responses queue up in send order; one walk at a time per test.
`timescale 1ns/10ps
module pwa_walker_tb_top;
    import pwa_pkg::*;
    logic        mclk, rst_n, bv0, bv1, rsp_bv, rvld, rrdy, rsv, drn, ext, wp, nwi, crl, ist, iwr, iwd, cat, slow, crw;
    logic [12:0] bd0, bd1;
    logic [11:0] rsp_bd;
    logic [7:0]  rop, cpr;
    logic [38:0] radr;
    logic [63:0] rdat;
    logic [2:0]  rmt, mt;
    logic [26:0] root;
    logic [35:0] va, prva;
    logic [19:0] asid;
    logic        uctx, prv;
    logic [47:0] rb, e, m, eq[$], mq[$];
    int          n_errors, tests_run, bc, lvl, n_ring, n_cat, n0;
    pwa_walker i_pwa_walker (.mclk(mclk), .rst_n(rst_n), .rq0_bv(bv0), .rq0_bd(bd0), .rq1_bv(bv1), .rq1_bd(bd1),
        .rsp_bv(rsp_bv), .rsp_bd(rsp_bd), .ring_req_valid(rvld), .ring_req_op(rop), .ring_req_addr(radr),
        .ring_req_ready(rrdy), .ring_rsp_valid(rsv), .ring_rsp_data(rdat), .ring_rsp_mtype(rmt),
        .ring_interface_drained(drn), .pt_root(root), .ctx_asid(asid), .user_ctx(uctx), .ext_access_en(ext),
        .wp_en(wp), .nonwb_ignore(nwi), .ctx_reload(crl), .inv_start(ist), .inv_wait_req(iwr), .inv_wait_done(iwd),
        .pg_resp_valid(prv), .pg_resp_va(prva), .pg_resp_asid(asid), .cluster_present(cpr), .cat_error(cat));
    pwa_ring_model i_pwa_ring_model (.mclk(mclk), .rst_n(rst_n), .req_valid(rvld), .req_op(rop), .req_addr(radr),
        .mtype(mt), .slow(slow), .req_ready(rrdy), .rsp_valid(rsv), .rsp_data(rdat), .rsp_mtype(rmt), .drained(drn));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [47:0] ex, input logic [47:0] g);
        tests_run++;
        if (g !== ex) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, ex, g);
        end
    endtask
    task automatic send(input bit p, input logic [51:0] r);
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk) #1;
            if (p) {bv1, bd1} = {1'b1, r[i*13 +: 13]};
            else {bv0, bd0} = {1'b1, r[i*13 +: 13]};
        end
    endtask
    task automatic req(input bit p, input bit rw, input logic [7:0] tg, input logic [47:0] mk);
        eq.push_back({tg, 3'h6, 2'h0, rw, 2'h1, 1'b0, p, rw, root + 27'h4, 2'h0});
        mq.push_back(mk);
        crw = rw;
        send(p, {2'h0, uctx, tg, rw, va, 2'h1, p, 1'b0});
    endtask
    task automatic drain();
        @(posedge mclk) #1;
        {bv0, bv1} = 2'b00;
        for (int i = 0; i < 500 && eq.size() != 0; i++) @(posedge mclk);
        chk("pending", 48'h0, 48'(eq.size()));
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge mclk) begin
        if (cat) n_cat = n_cat + 1;
        if (rvld && rrdy) begin
            chk("ring_op", {40'h0, 4'hc, lvl != 3, wp, ext, crw && lvl == 3}, {40'h0, rop});
            if (lvl == 0) chk("ring_root", {21'h0, root}, {21'h0, radr[38:12]});
            lvl = lvl + 1;
            n_ring = n_ring + 1;
        end
        if (rsp_bv) begin
            rb[bc*12 +: 12] = rsp_bd;
            bc = bc + 1;
        end
        if (bc == 4) begin
            {bc, lvl} = 0;
            e = (eq.size() != 0) ? eq.pop_front() : 48'h1;
            m = (mq.size() != 0) ? mq.pop_front() : 48'h1;
            chk("response", e & m, rb & m);
        end
    end
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #400000;
        n_errors++;
        close_out();
    end
    initial begin
        {rst_n, bv0, bv1, bd0, bd1, ext, wp, nwi, crl, ist, iwr, slow, crw, bc, lvl, n_ring, n_cat} = '0;
        {cpr, mt, root, asid, uctx, prv, prva} = {8'h11, 3'h6, 27'h12345, 20'h00001, 38'h0};
        void'($urandom(32'habdb));
        repeat (3) @(posedge mclk);
        #1 rst_n = 1'b1;
        for (int k = 0; k < 4; k++) begin
            {ext, wp, slow} = {k[1:0], k[0]};
            va = {4'($urandom), 32'($urandom)};
            req(k[0], 1'b0, 8'($urandom), '1);
            drain();
            req(k[0], 1'b1, 8'($urandom), '1);
            drain();
            $display("test walk %0d done", k);
        end
        n0 = n_ring;
        req(1'b0, 1'b1, 8'h00, '1);
        req(1'b0, 1'b1, 8'hff, '1);
        drain();
        chk("hit_no_walk", 48'(n0), 48'(n_ring));
        {mt, va} = {3'h1, 36'h0abc0};
        req(1'b1, 1'b0, 8'h5a, 48'hff18_0000_0003);
        eq[0] |= 48'h0008_0000_0000;
        drain();
        chk("cat_error", 48'h1, 48'(n_cat));
        {nwi, va} = {1'b1, 36'h0abc1};
        req(1'b1, 1'b0, 8'h5b, 48'hff1f_ffff_ffff);
        drain();
        chk("cat_error", 48'h1, 48'(n_cat));
        // Faultable user walk: cached as faulted, filtered once, then killed by a page response.
        {uctx, mt, va} = {1'b1, 3'h5, 36'h0abc2};
        for (int i = 0; i < 3; i++) begin
            n0 = n_ring;
            req(1'b1, 1'b0, 8'h61, 48'hff18_0000_0003);
            eq[0] |= 48'h0010_0000_0000;
            drain();
            chk("fault_walks", 48'(i != 1), 48'(n_ring - n0));
            if (i == 1) begin
                @(posedge mclk) #1;
                {prv, prva} = {1'b1, va};
                @(posedge mclk) #1;
                prv = 1'b0;
            end
        end
        $display("test fault filter done");
        mt = 3'h6;
        $display("test memory type done");
        for (int j = 0; j < 2; j++) begin
            eq.push_back(48'h2);
            mq.push_back(48'h3);
            @(posedge mclk) #1;
            {crl, ist} = {j[0], !j[0]};
            @(posedge mclk) #1;
            {crl, ist} = 2'b00;
            drain();
            eq.push_back(48'h3);
            mq.push_back(48'h3);
            send(1'b0, 52'h1);
            send(1'b1, 52'h3);
            drain();
            n0 = n_ring;
            req(1'b0, 1'b0, 8'h77, '1);
            drain();
            chk("flushed", 48'(n0 + 4), 48'(n_ring));
        end
        $display("test invalidation done");
        iwr = 1'b1;
        @(posedge mclk) #1;
        iwr = 1'b0;
        for (int i = 0; i < 50 && iwd !== 1'b1; i++) @(posedge mclk);
        chk("wait_done", 48'h1, {47'h0, iwd});
        $display("test wait done");
        close_out();
    end
endmodule // pwa_walker_tb_top
